/* src/btc_defines.svh */
// Constants for the bit-test, call and clear execution slice
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH
`define BTC_PC_W         11
`define BTC_RAM_AW       7
`define BTC_PC_HI_LSB    8
`define BTC_TABLE_HIGH_POINTER_LOW_W   3
`define BTC_STACK_AW     3
`define BTC_ACC_RST      8'h00
`define BTC_PC_RST       11'h000
`define BTC_SP_RST       3'h0
`define BTC_CALL_CYCLES  2
`define BTC_SKIP_CYCLES  2
`endif

/* src/btc_exec.sv */
// Execution core for bit-test skips, indirect call and clear/complement ops
`timescale 1ns/10ps
`include "btc_defines.svh"
module btc_exec #(
  parameter int PC_W  = `BTC_PC_W,
  parameter int STK_AW = `BTC_STACK_AW
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire btc_pkg::btc_instr_t instr,
  input  wire logic                instr_valid,
  input  wire logic [7:0]          reg_rdata,
  input  wire logic [7:0]          table_high_pointer,
  output logic [PC_W-1:0]          pc_out,
  output logic [7:0]               acc_out,
  output logic                     zero_flag,
  output btc_pkg::btc_wr_t         reg_wr,
  output logic [STK_AW-1:0]        stack_ptr,
  output logic [PC_W-1:0]          stack_top,
  output logic                     busy,
  output logic                     nop_slot
);
  // ==========================================================
  // State
  btc_pkg::btc_state_t   state_r, state_nxt;
  logic [PC_W-1:0]       pc_r, pc_nxt;
  logic [7:0]            acc_r, acc_nxt;
  logic                  z_r, z_nxt;
  btc_pkg::btc_wr_t      wr_r, wr_nxt;
  logic [STK_AW-1:0]     sp_r, sp_nxt;
  logic                  nop_r, nop_nxt;

  // ==========================================================
  // Decode
  // Inputs come from logic on this clock, so no synchronisers
  wire btc_pkg::btc_op_t op      = instr.op;
  wire logic             go      = instr_valid && (state_r == btc_pkg::BTC_ST_EXEC);
  // Read data must belong to instr.addr in the take cycle
  // Address is 7 bits and index 3 bits, so the whole operand range fits
  wire logic             tbit    = reg_rdata[instr.bit_idx];
  wire logic             skip_c  = (op == btc_pkg::BTC_OP_SKIP_CLR) && !tbit;
  wire logic             skip_s  = (op == btc_pkg::BTC_OP_SKIP_SET) && tbit;
  wire logic             skip    = go && (skip_c || skip_s);
  wire logic             call    = go && (op == btc_pkg::BTC_OP_CALL);
  wire logic [7:0]       inv     = ~reg_rdata;
  // Counter wraps at the top of program space
  wire logic [PC_W-1:0]  pc_inc  = PC_W'(pc_r + 1'b1);
  // Pointer and accumulator are taken in the second call cycle
  wire logic [PC_W-1:0]  call_pc = PC_W'({table_high_pointer[`BTC_TABLE_HIGH_POINTER_LOW_W-1:0],
                                          acc_r});
  wire logic             push    = call;
  wire logic [STK_AW-1:0] sp_inc = STK_AW'(sp_r + 1'b1);

  // Read slot wraps with the pointer, so the newest entry shows after eight calls
  wire logic [STK_AW-1:0] rd_slot = STK_AW'(sp_nxt - 1'b1);

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = btc_pkg::BTC_ST_EXEC;
    pc_nxt    = pc_r;
    acc_nxt   = acc_r;
    z_nxt     = z_r;
    wr_nxt    = '0;
    sp_nxt    = sp_r;
    nop_nxt   = 1'b0;
    unique case (state_r)
      btc_pkg::BTC_ST_EXEC: begin
        if (go) begin
          pc_nxt = pc_inc;
          unique case (op)
            btc_pkg::BTC_OP_SKIP_CLR,
            btc_pkg::BTC_OP_SKIP_SET: begin
              // A skip never writes a register or the flags
              if (skip) begin
                state_nxt = btc_pkg::BTC_ST_FLUSH;
              end
            end
            btc_pkg::BTC_OP_CALL: begin
              sp_nxt    = sp_inc;
              state_nxt = btc_pkg::BTC_ST_CALL2;
            end
            btc_pkg::BTC_OP_CLR_ACC: begin
              acc_nxt = `BTC_ACC_RST;
              z_nxt   = 1'b1;
            end
            btc_pkg::BTC_OP_CLR_REG: begin
              wr_nxt = '{we: 1'b1, addr: instr.addr, data: 8'h00};
              z_nxt  = 1'b1;
            end
            btc_pkg::BTC_OP_COMP_REG: begin
              if (instr.dest) begin
                wr_nxt = '{we: 1'b1, addr: instr.addr, data: inv};
              end else begin
                acc_nxt = inv;
              end
              z_nxt = (inv == 8'h00);
            end
            btc_pkg::BTC_OP_NOP: begin
            end
            default: begin
            end
          endcase
        end
      end
      btc_pkg::BTC_ST_FLUSH: begin
        // Prefetched word dropped; slot runs as NOP
        pc_nxt  = pc_inc;
        nop_nxt = 1'b1;
      end
      btc_pkg::BTC_ST_CALL2: begin
        pc_nxt = call_pc;
      end
      default: begin
      end
    endcase
  end

  // ==========================================================
  // Return stack
  // Eight entries; a ninth call overwrites the oldest
  btc_stack_mem #(
    .AW (STK_AW),
    .DW (PC_W)
  ) u_stack (
    .clk_sys (clk_sys),
    .we      (push),
    .waddr   (sp_r),
    .wdata   (pc_inc),
    .raddr   (rd_slot),
    .rdata   (stack_top)
  );

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= btc_pkg::BTC_ST_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pc_r <= `BTC_PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_r <= `BTC_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      z_r <= 1'b0;
    end else begin
      z_r <= z_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_r <= '0;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sp_r <= `BTC_SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nop_r <= 1'b0;
    end else begin
      nop_r <= nop_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // Taken from the next state so busy covers the FLUSH or CALL2 cycle
  logic busy_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != btc_pkg::BTC_ST_EXEC);
    end
  end

  assign pc_out    = pc_r;
  assign acc_out   = acc_r;
  assign zero_flag = z_r;
  assign reg_wr    = wr_r;
  assign stack_ptr = sp_r;
  assign busy      = busy_r;
  assign nop_slot  = nop_r;
endmodule

/* src/btc_pkg.sv */
// Types for the bit-test, call and clear execution slice
package btc_pkg;
  typedef enum logic [2:0] {
    BTC_OP_NOP      = 3'h0,
    BTC_OP_SKIP_CLR = 3'h1,
    BTC_OP_SKIP_SET = 3'h2,
    BTC_OP_CALL     = 3'h3,
    BTC_OP_CLR_ACC  = 3'h4,
    BTC_OP_CLR_REG  = 3'h5,
    BTC_OP_COMP_REG = 3'h6
  } btc_op_t;

  typedef struct packed {
    btc_op_t    op;
    logic [6:0] addr;
    logic [2:0] bit_idx;
    logic       dest;
  } btc_instr_t;

  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } btc_wr_t;

  typedef enum logic [1:0] {
    BTC_ST_EXEC = 2'h0,
    BTC_ST_FLUSH = 2'h1,
    BTC_ST_CALL2 = 2'h2
  } btc_state_t;
endpackage

/* src/btc_stack_mem.sv */
// Return address stack memory with registered read data
`timescale 1ns/10ps
module btc_stack_mem #(
  parameter int AW = 3,
  parameter int DW = 11
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* tb/btc_exec_asserts.sv */
// Port checks for the execution slice
`timescale 1ns/10ps
module btc_exec_asserts #(
  parameter int PC_W   = 11,
  parameter int STK_AW = 3
) (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire btc_pkg::btc_instr_t instr,
  input wire logic                instr_valid,
  input wire logic [7:0]          reg_rdata,
  input wire logic [7:0]          table_high_pointer,
  input wire logic [PC_W-1:0]     pc_out,
  input wire logic [7:0]          acc_out,
  input wire logic                zero_flag,
  input wire btc_pkg::btc_wr_t    reg_wr,
  input wire logic [STK_AW-1:0]   stack_ptr,
  input wire logic [PC_W-1:0]     stack_top,
  input wire logic                busy,
  input wire logic                nop_slot
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ========================================
  // Checks
  wire logic             take = instr_valid && !busy;
  wire logic [2:0]       op   = instr.op;
  wire logic             hit  = reg_rdata[instr.bit_idx];
  wire logic [PC_W-1:0]  tgt  = {table_high_pointer[2:0], acc_out};
  AST_CLR_ACC: assert property (take && op == 3'h4 |=> acc_out == 8'h00 && zero_flag)
    else $error("acc clear");
  AST_CLR_REG: assert property (take && op == 3'h5 |=>
    reg_wr.we && reg_wr.data == 8'h00 && zero_flag && reg_wr.addr == $past(instr.addr))
    else $error("reg clear");
  AST_COM_ACC: assert property (take && op == 3'h6 && !instr.dest |=>
    acc_out == ~$past(reg_rdata) && zero_flag == (acc_out == 8'h00) && !reg_wr.we)
    else $error("comp to acc");
  AST_COM_REG: assert property (take && op == 3'h6 && instr.dest |=>
    reg_wr.we && reg_wr.data == ~$past(reg_rdata) && zero_flag == (reg_wr.data == 8'h00))
    else $error("comp to reg");
  AST_SKIP_CLR: assert property (take && op == 3'h1 && !hit |=> busy ##1 !busy && nop_slot)
    else $error("skip clr");
  AST_SKIP_SET: assert property (take && op == 3'h2 && hit |=> busy ##1 !busy && nop_slot)
    else $error("skip set");
  AST_NO_SKIP: assert property (take && (op == 3'h1 && hit || op == 3'h2 && !hit) |=>
    !busy && pc_out == PC_W'($past(pc_out) + 1))
    else $error("no skip");
  AST_CALL: assert property (take && op == 3'h3 |=>
    busy && stack_ptr == STK_AW'($past(stack_ptr) + 1) && pc_out == PC_W'($past(pc_out) + 1)
    ##1 pc_out == $past(tgt) && stack_top == $past(pc_out))
    else $error("call");
endmodule
bind btc_exec btc_exec_asserts #(.PC_W(PC_W), .STK_AW(STK_AW)) u_chk (.clk_sys, .sys_rst,
  .instr, .instr_valid, .reg_rdata, .table_high_pointer, .pc_out, .acc_out, .zero_flag,
  .reg_wr, .stack_ptr, .stack_top, .busy, .nop_slot);

/* tb/btc_exec_tb_top.sv */
// Self-checking bench for the execution slice
`timescale 1ns/10ps
module btc_exec_tb_top;
  logic                clk_sys = 1'b0;
  logic                sys_rst = 1'b1;
  btc_pkg::btc_instr_t instr = '0;
  logic                instr_valid = 1'b0;
  logic [7:0]          reg_rdata = 8'h00;
  logic [7:0]          table_high_pointer = 8'h00;
  logic [10:0]         pc_out, stack_top;
  logic [7:0]          acc_out;
  logic                zero_flag, busy, nop_slot;
  logic [2:0]          stack_ptr;
  btc_pkg::btc_wr_t    reg_wr;
  logic [15:0]         lfsr = 16'hef6d;
  int n_errors = 0, checked = 0, pc = 0, acc = 0, z = 0, sp = 0, r, v, sk, we, c, k;
  int stk[$];
  btc_exec uut (.clk_sys, .sys_rst, .instr, .instr_valid, .reg_rdata, .table_high_pointer,
    .pc_out, .acc_out, .zero_flag, .reg_wr, .stack_ptr, .stack_top, .busy, .nop_slot);
  always #50 clk_sys = ~clk_sys;
  // ========================================
  // Helpers
  function automatic int nx();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return int'(lfsr);
  endfunction
  task automatic chk(input logic [10:0] g, input int e);
    checked++;
    if (g !== 11'(e)) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, 11'(e));
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ========================================
  // Random instruction stream; valid stays up through busy cycles, which must refuse it
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 300; i++) begin
      r = nx();
      instr = {btc_pkg::btc_op_t'(3'(r % 7)), r[9:3], r[12:10], r[13]};
      reg_rdata = 8'(nx());
      table_high_pointer = 8'(nx());
      instr_valid = r[15:14] != 2'b00;
      k = instr_valid ? r % 7 : -1;
      sk = 0;
      we = 0;
      c = k == 3;
      case (k)
        1: sk = !reg_rdata[instr.bit_idx];
        2: sk = reg_rdata[instr.bit_idx];
        3: stk.push_back(pc + 1);
        4: acc = 0;
        5: v = 0;
        6: v = 255 - reg_rdata;
        default: ;
      endcase
      if (c) sp = (sp + 1) % 8;
      if (k > 3) z = k == 6 ? v == 0 : 1;
      if (k == 5 || k == 6 && instr.dest) we = 1;
      if (k == 6 && !instr.dest) acc = v;
      pc = c ? table_high_pointer[2:0] * 256 + acc : (pc + instr_valid + sk) % 2048;
      @(posedge clk_sys);
      #1 chk(reg_wr.we, we);
      chk(busy, sk || c);
      if (we) chk(reg_wr.data, v);
      if (we) chk(reg_wr.addr, instr.addr);
      if (sk || c) begin
        @(posedge clk_sys);
        #1;
      end
      chk(pc_out, pc);
      chk(acc_out, acc);
      chk(zero_flag, z);
      chk(stack_ptr, sp);
      chk(nop_slot, sk);
      if (c) chk(stack_top, stk[$]);
    end
    $display("random stream done");
    finish_test();
  end
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule
